// ---- verilog/uimc_pkg.sv ----
/*
  package for the serial port interrupt and modem control block: register offsets,
  field positions, reset values, interrupt codes and the shared state carrier.
  assumes an apb slave with 32-bit data and one aligned word per register.
*/
`default_nettype none
package uimc_pkg;
  // register byte offsets
  localparam logic [7:0] UIMC_OFF_INTERRUPT_ENABLE  = 8'h04;
  localparam logic [7:0] UIMC_OFF_INTERRUPT_IDENT   = 8'h08;
  localparam logic [7:0] UIMC_OFF_FIFO_CONTROL      = 8'h0c;
  localparam logic [7:0] UIMC_OFF_MODEM_CONTROL     = 8'h10;
  localparam logic [7:0] UIMC_OFF_MODEM_STATUS      = 8'h18;
  localparam logic [7:0] UIMC_OFF_SCRATCH           = 8'h1c;
  localparam logic [7:0] UIMC_OFF_RX_STATUS         = 8'h20;
  localparam logic [7:0] UIMC_OFF_CHAR_TIME         = 8'h24;
  // field positions
  localparam int UIMC_LOOP_BIT     = 4;
  localparam int UIMC_FIFO_EN_BIT  = 0;
  localparam int UIMC_TRIG_LSB     = 6;
  // reset values
  localparam logic [7:0]  UIMC_RST_BYTE      = 8'h00;
  localparam logic [15:0] UIMC_RST_CHAR_TIME = 16'h00a0;
  // identification codes, bits 3..0
  localparam logic [3:0] UIMC_ID_NONE    = 4'h1;
  localparam logic [3:0] UIMC_ID_LINE    = 4'h6;
  localparam logic [3:0] UIMC_ID_RXDATA  = 4'h4;
  localparam logic [3:0] UIMC_ID_TIMEOUT = 4'hc;
  localparam logic [3:0] UIMC_ID_TXEMPTY = 4'h2;
  localparam logic [3:0] UIMC_ID_MODEM   = 4'h0;
  // character times before a receive timeout
  localparam logic [2:0] UIMC_TIMEOUT_CHARS = 3'h4;
  // trigger levels 1, 4, 8, 14
  localparam logic [4:0] UIMC_TRIG_1  = 5'h01;
  localparam logic [4:0] UIMC_TRIG_4  = 5'h04;
  localparam logic [4:0] UIMC_TRIG_8  = 5'h08;
  localparam logic [4:0] UIMC_TRIG_14 = 5'h0e;

  typedef struct packed {
    logic [3:0]  int_enable;
    logic [7:0]  fcr;
    logic [4:0]  modem_ctl;
    logic [3:0]  modem_delta;
    logic [3:0]  modem_prev;
    logic [7:0]  scratch;
    logic [7:0]  ident;
    logic        ident_freeze;
    logic        txe_pend;
    logic        txe_prev;
    logic        saw_two;
    logic        first_txe;
    logic [15:0] char_time;
    logic [15:0] tick_cnt;
    logic [2:0]  char_cnt;
    logic        timeout_pend;
    logic [15:0] delay_cnt;
    logic        delay_run;
    logic        data_ready;
    logic [31:0] prdata;
  } uimc_state_type;

  // modem inputs as seen by the block, active high
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } uimc_modem_type;
endpackage
`default_nettype wire

// ---- verilog/uimc_top.sv ----
/*
  interrupt identification, interrupt enable, modem control/status, scratch and
  fifo interrupt rules of a serial port, reached over apb.
  assumes the receiver, transmitter and fifos sit outside and report fill levels
  and one-cycle strobes synchronous to mclk.
*/
// Added by the designer: register access over APB and the placing of the registers.
`default_nettype none
module uimc_top (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        dcd_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             out1_n,
  output logic             out2_n,
  input  wire logic        serial_input,
  input  wire logic        tx_shift_out,
  output logic             serial_output,
  output logic             rx_shift_in,
  input  wire logic        line_status_pend,
  input  wire logic        rx_push,
  input  wire logic        rx_pop,
  input  wire logic [4:0]  rx_fill,
  input  wire logic        rx_char_pend,
  input  wire logic        thr_write,
  input  wire logic [4:0]  tx_fill,
  input  wire logic        tx_empty,
  input  wire logic        rclk_tick,
  output logic             fifo_enable_bit,
  output logic             fifo_clear,
  output logic             data_ready_bit,
  output logic             interrupt_output
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]                 rst_sync_reg;
  logic                       rst_n;
  uimc_pkg::uimc_state_type   s_reg;
  uimc_pkg::uimc_state_type   s_next;
  uimc_pkg::uimc_modem_type   modem_in;
  logic                       rd_access;
  logic                       wr_access;
  logic                       loop;
  logic                       fifo_mode;
  logic                       rx_pend;
  logic                       txe_src;
  logic                       modem_pend;
  logic                       line_en;
  logic [4:0]                 trigger;
  logic [3:0]                 id_live;
  logic                       txe_level;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_level = uimc_pkg::UIMC_TRIG_1;
      2'h1:    trig_level = uimc_pkg::UIMC_TRIG_4;
      2'h2:    trig_level = uimc_pkg::UIMC_TRIG_8;
      default: trig_level = uimc_pkg::UIMC_TRIG_14;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // single-cycle access: answer in the first access cycle
  assign pready    = 1'b1;
  assign rd_access = psel && penable && !pwrite;
  assign wr_access = psel && penable && pwrite;
  assign pslverr   = psel && penable && !(
    hit(paddr, uimc_pkg::UIMC_OFF_INTERRUPT_ENABLE) ||
    hit(paddr, uimc_pkg::UIMC_OFF_INTERRUPT_IDENT) ||
    hit(paddr, uimc_pkg::UIMC_OFF_FIFO_CONTROL) ||
    hit(paddr, uimc_pkg::UIMC_OFF_MODEM_CONTROL) ||
    hit(paddr, uimc_pkg::UIMC_OFF_MODEM_STATUS) ||
    hit(paddr, uimc_pkg::UIMC_OFF_SCRATCH) ||
    hit(paddr, uimc_pkg::UIMC_OFF_RX_STATUS) ||
    hit(paddr, uimc_pkg::UIMC_OFF_CHAR_TIME));
  assign prdata    = s_reg.prdata;

  assign loop      = s_reg.modem_ctl[uimc_pkg::UIMC_LOOP_BIT];
  assign fifo_mode = s_reg.fcr[uimc_pkg::UIMC_FIFO_EN_BIT];
  assign fifo_enable_bit = fifo_mode;
  assign trigger   = trig_level(s_reg.fcr[uimc_pkg::UIMC_TRIG_LSB +: 2]);

  // modem inputs, active high; loopback takes the control bits instead
  always_comb begin
    if (loop) begin
      modem_in.cts = s_reg.modem_ctl[1];
      modem_in.dsr = s_reg.modem_ctl[0];
      modem_in.ri  = s_reg.modem_ctl[2];
      modem_in.dcd = s_reg.modem_ctl[3];
    end else begin
      modem_in.cts = !cts_n;
      modem_in.dsr = !dsr_n;
      modem_in.ri  = !ri_n;
      modem_in.dcd = !dcd_n;
    end
  end

  // pins held inactive high in loopback
  assign dtr_n  = loop ? 1'b1 : !s_reg.modem_ctl[0];
  assign rts_n  = loop ? 1'b1 : !s_reg.modem_ctl[1];
  assign out1_n = loop ? 1'b1 : !s_reg.modem_ctl[2];
  assign out2_n = loop ? 1'b1 : !s_reg.modem_ctl[3];
  assign serial_output = loop ? 1'b1 : tx_shift_out;
  assign rx_shift_in   = loop ? tx_shift_out : serial_input;
  assign data_ready_bit = s_reg.data_ready;

  ////////////////////////////////////////////////////////////////////////////
  // pending sources, each gated by its enable
  assign line_en    = s_reg.int_enable[2] && line_status_pend;
  // trigger level and timeout only in fifo mode; character mode uses rx_char_pend
  assign rx_pend    = s_reg.int_enable[0] &&
                      (fifo_mode ? (rx_fill >= trigger) || s_reg.timeout_pend
                                 : rx_char_pend);
  assign txe_src    = s_reg.int_enable[1] && s_reg.txe_pend;
  assign modem_pend = s_reg.int_enable[3] && (s_reg.modem_delta != 4'h0);

  always_comb begin
    if (line_en) begin
      id_live = uimc_pkg::UIMC_ID_LINE;
    end else if (rx_pend) begin
      id_live = (fifo_mode && s_reg.timeout_pend && rx_fill < trigger)
              ? uimc_pkg::UIMC_ID_TIMEOUT : uimc_pkg::UIMC_ID_RXDATA;
    end else if (txe_src) begin
      id_live = uimc_pkg::UIMC_ID_TXEMPTY;
    end else if (modem_pend) begin
      id_live = uimc_pkg::UIMC_ID_MODEM;
    end else begin
      id_live = uimc_pkg::UIMC_ID_NONE;
    end
  end

  assign interrupt_output = line_en || rx_pend || txe_src || modem_pend;

  // transmit empty level: fifo empty, or holding empty in character mode
  assign txe_level = tx_empty;
  assign fifo_clear = wr_access && hit(paddr, uimc_pkg::UIMC_OFF_FIFO_CONTROL) &&
                      (pwdata[uimc_pkg::UIMC_FIFO_EN_BIT] != fifo_mode);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.prdata = 32'h0;

    // change flags: set wins over clear by read
    if (rd_access && hit(paddr, uimc_pkg::UIMC_OFF_MODEM_STATUS)) begin
      s_next.modem_delta = 4'h0;
    end
    s_next.modem_delta[0] = s_next.modem_delta[0] | (modem_in.cts ^ s_reg.modem_prev[0]);
    s_next.modem_delta[1] = s_next.modem_delta[1] | (modem_in.dsr ^ s_reg.modem_prev[1]);
    // trailing ring edge: pin goes low to high, so active-high ri falls
    s_next.modem_delta[2] = s_next.modem_delta[2] | (!modem_in.ri && s_reg.modem_prev[2]);
    s_next.modem_delta[3] = s_next.modem_delta[3] | (modem_in.dcd ^ s_reg.modem_prev[3]);
    s_next.modem_prev = {modem_in.dcd, modem_in.ri, modem_in.dsr, modem_in.cts};

    // identification held while the host read is in progress
    s_next.ident_freeze = psel && !pwrite && hit(paddr, uimc_pkg::UIMC_OFF_INTERRUPT_IDENT);
    if (!s_next.ident_freeze || !s_reg.ident_freeze) begin
      s_next.ident = {fifo_mode, fifo_mode, 2'h0, fifo_mode ? id_live : {1'b0, id_live[2:0]}};
    end

    // data ready: set on push, cleared only when the fifo empties
    if (rx_push) begin
      s_next.data_ready = 1'b1;
    end else if (rx_fill == 5'h00) begin
      s_next.data_ready = 1'b0;
    end

    // receive timeout timer counted in receive character times
    if (rx_push || rx_pop || !fifo_mode || rx_fill == 5'h00) begin
      s_next.tick_cnt     = 16'h0;
      s_next.char_cnt     = 3'h0;
      s_next.timeout_pend = 1'b0;
    end else if (rclk_tick && !s_reg.timeout_pend) begin
      if (s_reg.tick_cnt + 16'h1 >= s_reg.char_time) begin
        s_next.tick_cnt = 16'h0;
        s_next.char_cnt = s_reg.char_cnt + 3'h1;
        if (s_reg.char_cnt + 3'h1 >= uimc_pkg::UIMC_TIMEOUT_CHARS) begin
          s_next.timeout_pend = 1'b1;
        end
      end else begin
        s_next.tick_cnt = s_reg.tick_cnt + 16'h1;
      end
    end

    // transmit empty with the one-character delay
    if (tx_fill >= 5'h02) begin
      s_next.saw_two = 1'b1;
    end
    s_next.txe_prev = txe_level;
    if (txe_level && !s_reg.txe_prev) begin
      if (fifo_mode && !s_reg.saw_two && !s_reg.first_txe) begin
        s_next.delay_run = 1'b1;
        s_next.delay_cnt = 16'h0;
      end else begin
        s_next.txe_pend = 1'b1;
      end
      s_next.saw_two   = 1'b0;
      s_next.first_txe = 1'b0;
    end
    if (s_reg.delay_run && rclk_tick) begin
      if (s_reg.delay_cnt + 16'h1 >= s_reg.char_time) begin
        s_next.delay_run = 1'b0;
        s_next.txe_pend  = txe_level;
      end else begin
        s_next.delay_cnt = s_reg.delay_cnt + 16'h1;
      end
    end
    if (thr_write || !txe_level ||
        (rd_access && hit(paddr, uimc_pkg::UIMC_OFF_INTERRUPT_IDENT) &&
         s_reg.ident[3:0] == uimc_pkg::UIMC_ID_TXEMPTY)) begin
      s_next.txe_pend  = 1'b0;
      s_next.delay_run = 1'b0;
    end

    // register writes
    if (wr_access) begin
      if (hit(paddr, uimc_pkg::UIMC_OFF_INTERRUPT_ENABLE)) begin
        s_next.int_enable = pwdata[3:0];
      end
      if (hit(paddr, uimc_pkg::UIMC_OFF_FIFO_CONTROL)) begin
        if (pwdata[uimc_pkg::UIMC_FIFO_EN_BIT] != fifo_mode) begin
          s_next.first_txe = 1'b1;
          s_next.txe_prev  = 1'b0;
        end
        s_next.fcr = pwdata[uimc_pkg::UIMC_FIFO_EN_BIT] ? pwdata[7:0] : 8'h00;
      end
      if (hit(paddr, uimc_pkg::UIMC_OFF_MODEM_CONTROL)) begin
        s_next.modem_ctl = pwdata[4:0];
      end
      if (hit(paddr, uimc_pkg::UIMC_OFF_SCRATCH)) begin
        s_next.scratch = pwdata[7:0];
      end
      if (hit(paddr, uimc_pkg::UIMC_OFF_CHAR_TIME)) begin
        s_next.char_time = (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
      end
    end

    // read data registered in the setup cycle, shown in the access cycle
    if (psel && !penable && !pwrite) begin
      case (paddr)
        uimc_pkg::UIMC_OFF_INTERRUPT_ENABLE: s_next.prdata = {28'h0, s_reg.int_enable};
        uimc_pkg::UIMC_OFF_INTERRUPT_IDENT:  s_next.prdata = {24'h0, s_next.ident};
        uimc_pkg::UIMC_OFF_FIFO_CONTROL:     s_next.prdata = {24'h0, s_reg.fcr};
        uimc_pkg::UIMC_OFF_MODEM_CONTROL:    s_next.prdata = {27'h0, s_reg.modem_ctl};
        uimc_pkg::UIMC_OFF_MODEM_STATUS:     s_next.prdata = {24'h0, modem_in.dcd,
          modem_in.ri, modem_in.dsr, modem_in.cts, s_next.modem_delta};
        uimc_pkg::UIMC_OFF_SCRATCH:          s_next.prdata = {24'h0, s_reg.scratch};
        uimc_pkg::UIMC_OFF_RX_STATUS:        s_next.prdata = {30'h0, s_reg.timeout_pend,
          s_reg.data_ready};
        uimc_pkg::UIMC_OFF_CHAR_TIME:        s_next.prdata = {16'h0, s_reg.char_time};
        default:                             s_next.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg           <= '0;
      s_reg.ident     <= {4'h0, uimc_pkg::UIMC_ID_NONE};
      s_reg.char_time <= uimc_pkg::UIMC_RST_CHAR_TIME;
      s_reg.modem_prev <= 4'h0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule
`default_nettype wire

// ---- test/uimc_top_asserts.sv ----
/* port checker for uimc_top: read fields, modem pins, loopback, data ready.
   assumes it is bound to the top module and sees only its ports. */
`default_nettype none
module uimc_top_asserts (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        cts_n,
  input wire logic        dsr_n,
  input wire logic        ri_n,
  input wire logic        dcd_n,
  input wire logic        dtr_n,
  input wire logic        rts_n,
  input wire logic        out1_n,
  input wire logic        out2_n,
  input wire logic        serial_input,
  input wire logic        tx_shift_out,
  input wire logic        serial_output,
  input wire logic        rx_shift_in,
  input wire logic        rx_push,
  input wire logic        fifo_enable_bit,
  input wire logic        fifo_clear,
  input wire logic        data_ready_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite && pready;
  property p_ident_fix;
    rd_acc && paddr == uimc_pkg::UIMC_OFF_INTERRUPT_IDENT
    |-> prdata[5:4] == 2'h0 && prdata[7:6] == {2{fifo_enable_bit}};
  endproperty
  a_ident_fix: assert property (p_ident_fix) else $error("ident fixed bits wrong");
  property p_ident_char;
    rd_acc && paddr == uimc_pkg::UIMC_OFF_INTERRUPT_IDENT && !fifo_enable_bit |-> !prdata[3];
  endproperty
  a_ident_char: assert property (p_ident_char) else $error("ident bit3 in char mode");
  property p_ier_rd;
    rd_acc && paddr == uimc_pkg::UIMC_OFF_INTERRUPT_ENABLE |-> prdata[31:4] == 28'h0;
  endproperty
  a_ier_rd: assert property (p_ier_rd) else $error("enable upper bits set");
  property p_mcr_rd;
    rd_acc && paddr == uimc_pkg::UIMC_OFF_MODEM_CONTROL |-> prdata[31:5] == 27'h0;
  endproperty
  a_mcr_rd: assert property (p_mcr_rd) else $error("control upper bits set");
  property p_loop;
    serial_output && !tx_shift_out
    |-> {dtr_n, rts_n, out1_n, out2_n} == 4'hf && rx_shift_in == tx_shift_out;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback pins wrong");
  property p_normal;
    !(dtr_n && rts_n && out1_n && out2_n)
    |-> serial_output == tx_shift_out && rx_shift_in == serial_input;
  endproperty
  a_normal: assert property (p_normal) else $error("serial path wrong");
  property p_msr_pins;
    rd_acc && paddr == uimc_pkg::UIMC_OFF_MODEM_STATUS && !dtr_n &&
    $stable({dcd_n, ri_n, dsr_n, cts_n})
    |-> prdata[7:4] == ~{dcd_n, ri_n, dsr_n, cts_n};
  endproperty
  a_msr_pins: assert property (p_msr_pins) else $error("status levels wrong");
  property p_push;
    fifo_enable_bit && rx_push |=> data_ready_bit;
  endproperty
  a_push: assert property (p_push) else $error("data ready not set");
  property p_fifo_clr;
    psel && penable && pwrite && paddr == uimc_pkg::UIMC_OFF_FIFO_CONTROL &&
    pwdata[0] != fifo_enable_bit |-> fifo_clear ##1 fifo_enable_bit == $past(pwdata[0]);
  endproperty
  a_fifo_clr: assert property (p_fifo_clr) else $error("fifo toggle not cleared");
  property p_unmapped;
    psel && penable && !(paddr inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c,
      8'h20, 8'h24}) |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
endmodule
bind uimc_top uimc_top_asserts u_chk (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .prdata, .cts_n, .dsr_n, .ri_n, .dcd_n, .dtr_n, .rts_n,
  .out1_n, .out2_n, .serial_input, .tx_shift_out, .serial_output, .rx_shift_in, .rx_push,
  .fifo_enable_bit, .fifo_clear, .data_ready_bit);
`default_nettype wire

// ---- test/uimc_modem_model.sv ----
/* far side model: modem lines, receive bit tick, serial data lines.
   assumes the bench asks for modem pin levels and tick running. */
`default_nettype none
module uimc_modem_model (
  input  wire logic       mclk,
  input  wire logic [3:0] pins_req,
  input  wire logic       tick_en,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ri_n,
  output logic            dcd_n,
  output logic            rclk_tick,
  output logic            tx_shift_out,
  output logic            serial_input
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div;
  initial begin
    {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
    {div, rclk_tick, tx_shift_out, serial_input} = '0;
  end
  // tx_shift_out takes a random bit every cycle and serial_input the inverse of its last one, so a stale bit never passes for a looped one
  always @(posedge mclk) begin
    {dcd_n, ri_n, dsr_n, cts_n} <= pins_req;
    div <= div + 2'h1;
    rclk_tick <= tick_en && div == 2'h3;
    tx_shift_out <= 1'($urandom());
    serial_input <= ~tx_shift_out;
  end
endmodule
`default_nettype wire

// ---- test/uimc_top_test.sv ----
/* self-checking bench for uimc_top over apb with a modem line model.
   assumes zero-wait apb and fifo status driven by the bench. */
`default_nettype none
module uimc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] IEN = 8'h04, IID = 8'h08, FCR = 8'h0c, MCT = 8'h10;
  localparam logic [7:0] MST = 8'h18, SPD = 8'h1c, CHT = 8'h24;
  localparam logic [4:0] TRIG [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  localparam logic [3:0] PINS [5] = '{4'he, 4'ha, 4'he, 4'h6, 4'h4};
  localparam logic [7:0] IDX [5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MSX [5] = '{8'h11, 8'h50, 8'h14, 8'h98, 8'hb2};
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, r;
  logic [31:0] pwdata, prdata;
  logic        cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, out1_n, out2_n, tick_en;
  logic        serial_input, tx_shift_out, serial_output, rx_shift_in, line_status_pend;
  logic        rx_push, rx_pop, rx_char_pend, thr_write, tx_empty, rclk_tick;
  logic        fifo_enable_bit, fifo_clear, data_ready_bit, interrupt_output;
  logic [4:0]  rx_fill, tx_fill;
  logic [3:0]  pins_req, m;
  logic [7:0]  exp_q[$], mask_q[$];
  int          err_total, comparisons, cycles;
  uimc_top dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .cts_n, .dsr_n, .ri_n, .dcd_n, .dtr_n, .rts_n, .out1_n, .out2_n,
    .serial_input, .tx_shift_out, .serial_output, .rx_shift_in, .line_status_pend,
    .rx_push, .rx_pop, .rx_fill, .rx_char_pend, .thr_write, .tx_fill, .tx_empty,
    .rclk_tick, .fifo_enable_bit, .fifo_clear, .data_ready_bit, .interrupt_output);
  uimc_modem_model u_far (.mclk, .pins_req, .tick_en, .cts_n, .dsr_n, .ri_n, .dcd_n,
    .rclk_tick, .tx_shift_out, .serial_input);
  always #20 mclk = ~mclk;
  task automatic print_verdict();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
    check_reg(got, exp);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
    exp_q.push_back(e & k);
    mask_q.push_back(k);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_int();
    for (int n = 0; n < 300 && interrupt_output !== 1'b1; n++) @(posedge mclk);
  endtask
  // a read result is compared at the access edge, where prdata is valid
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
    if (psel && penable && !pwrite && pready) begin
      check_reg(prdata[7:0] & mask_q.pop_front(), exp_q.pop_front());
    end
  end
  initial begin
    {mclk, reset_n, psel, penable, pwrite, line_status_pend, rx_push, rx_pop} = '0;
    {rx_char_pend, thr_write, tx_empty, tick_en, paddr, pwdata, rx_fill, tx_fill} = '0;
    {err_total, comparisons, cycles} = '0;
    pins_req = 4'hf;
    void'($urandom(32'h3608));
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(IEN, 8'h00, 8'hff);
    rd(MCT, 8'h00, 8'hff);
    rd(IID, 8'h01, 8'hff);
    r = 8'($urandom());
    wr(SPD, r);
    wr(IEN, 8'hff);
    rd(SPD, r, 8'hff);
    rd(IEN, 8'h0f, 8'hff);
    $display("registers done");
    wr(MCT, 8'h01);
    rd(MST, 8'h00, 8'hf0);
    for (int i = 0; i < 5; i++) begin
      wr(IEN, i == 0 ? 8'h00 : 8'h08);
      pins_req <= PINS[i];
      repeat (4) @(posedge mclk);
      check_pin({7'h0, interrupt_output}, {7'h0, ~IDX[i][0]});
      rd(IID, IDX[i], 8'hff);
      rd(MST, MSX[i], 8'hff);
    end
    $display("modem status done");
    m = 4'($urandom());
    wr(MCT, {4'h0, m});
    check_pin({4'h0, out2_n, out1_n, rts_n, dtr_n}, {4'h0, ~m});
    wr(MCT, {4'h1, m});
    check_pin({3'h0, serial_output, out2_n, out1_n, rts_n, dtr_n}, 8'h1f);
    rd(MST, {m[3], m[2], m[0], m[1], 4'h0}, 8'hf0);
    wr(MCT, {4'h1, m ^ 4'h1});
    @(posedge mclk);
    check_pin({7'h0, interrupt_output}, 8'h01);
    rd(MST, {m[3], m[2], ~m[0], m[1], 4'h2}, 8'hff);
    wr(MCT, 8'h00);
    rd(MST, 8'hb0, 8'hf0);
    $display("loopback done");
    wr(IEN, 8'h0d);
    rx_char_pend <= 1'b1;
    @(posedge mclk);
    rd(IID, 8'h04, 8'hff);
    rx_char_pend <= 1'b0;
    for (int t = 0; t < 4; t++) begin
      wr(FCR, {2'(t), 6'h01});
      rx_fill <= TRIG[t] - 5'h1;
      line_status_pend <= 1'b1;
      @(posedge mclk);
      rd(IID, 8'hc6, 8'hff);
      line_status_pend <= 1'b0;
      @(posedge mclk);
      rd(IID, 8'hc1, 8'hff);
      rx_fill <= TRIG[t];
      line_status_pend <= t[0];
      @(posedge mclk);
      rd(IID, t[0] ? 8'hc6 : 8'hc4, 8'hff);
      line_status_pend <= 1'b0;
      @(posedge mclk);
      rd(IID, 8'hc4, 8'hff);
    end
    rx_push <= 1'b1;
    @(posedge mclk);
    rx_push <= 1'b0;
    @(posedge mclk);
    check_pin({7'h0, data_ready_bit}, 8'h01);
    rx_fill <= 5'h0;
    repeat (2) @(posedge mclk);
    check_pin({7'h0, data_ready_bit}, 8'h00);
    wr(CHT, 8'h02);
    rx_fill <= 5'h1;
    tick_en <= 1'b1;
    repeat (12) @(posedge mclk);
    check_pin({7'h0, interrupt_output}, 8'h00);
    wait_int();
    rd(IID, 8'hcc, 8'hff);
    rx_pop <= 1'b1;
    @(posedge mclk);
    rx_pop <= 1'b0;
    @(posedge mclk);
    rd(IID, 8'hc1, 8'hff);
    wr(IEN, 8'h00);
    rx_fill <= 5'h0e;
    repeat (60) @(posedge mclk);
    check_pin({7'h0, interrupt_output}, 8'h00);
    rx_fill <= 5'h0;
    $display("receive fifo done");
    wr(FCR, 8'h00);
    wr(FCR, 8'h01);
    wr(IEN, 8'h02);
    tx_empty <= 1'b1;
    @(posedge mclk);
    rd(IID, 8'hc2, 8'hff);
    rd(IID, 8'hc1, 8'hff);
    {tx_empty, tx_fill, thr_write} <= {1'b0, 5'h1, 1'b1};
    @(posedge mclk);
    {tx_empty, tx_fill, thr_write} <= {1'b1, 5'h0, 1'b0};
    repeat (2) @(posedge mclk);
    check_pin({7'h0, interrupt_output}, 8'h00);
    wait_int();
    check_pin({7'h0, interrupt_output}, 8'h01);
    {tx_empty, tx_fill, thr_write} <= {1'b0, 5'h1, 1'b1};
    @(posedge mclk);
    thr_write <= 1'b0;
    @(posedge mclk);
    check_pin({7'h0, interrupt_output}, 8'h00);
    rd(8'h3c, 8'h00, 8'hff);
    $display("transmit and refusal done");
    print_verdict();
  end
endmodule
`default_nettype wire
